// >>> logic/mlfc_top.sv
// Motor lock fault configuration register and lock response logic.
`timescale 1ns/1ps
module mlfc_top #(
    parameter int RETRY_CYCLES = mlfc_pkg::RETRY_INTERVAL_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic cfg_wr_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    input wire logic current_limit_lock_i,
    input wire logic fault_clear_i,
    output mlfc_pkg::mlfc_detect_type detect_cfg_o,
    output mlfc_pkg::mlfc_drive_type drive_o,
    output logic fault_indicator_pin_n_o,
    output logic fault_latched_o
);
    // A zero interval would wrap the expiry compare to all ones, so the timer would take 2^32 cycles to expire.
    if (RETRY_CYCLES < 1) begin : g_bad_retry
        $error("RETRY_CYCLES must be at least one.");
    end

    typedef struct packed {
        logic [31:0] settings;
        mlfc_pkg::mlfc_state_type state;
        mlfc_pkg::mlfc_resp_type resp;
        logic [31:0] timer;
        logic [3:0] retries;
        logic lock_s1;
        logic lock_s2;
        logic clr_s1;
        logic clr_s2;
    } mlfc_regs_type;

    mlfc_regs_type state_r;
    mlfc_regs_type state_nxt;
    mlfc_pkg::mlfc_resp_type mode;
    logic [2:0] limit;
    logic lock;

    function automatic mlfc_pkg::mlfc_drive_type act_of(
        input mlfc_pkg::mlfc_resp_type r);
        case (r)
            mlfc_pkg::RESP_LATCH_LOW, mlfc_pkg::RESP_RETRY_LOW:
                act_of = mlfc_pkg::DRV_LOW_BRAKE;
            mlfc_pkg::RESP_LATCH_HIGH, mlfc_pkg::RESP_RETRY_HIGH:
                act_of = mlfc_pkg::DRV_HIGH_BRAKE;
            default: act_of = mlfc_pkg::DRV_HIZ;
        endcase
    endfunction

    assign mode = mlfc_pkg::mlfc_resp_type'(
        state_r.settings[mlfc_pkg::RESPONSE_LSB +: 3]);
    assign limit = state_r.settings[mlfc_pkg::RETRY_LIMIT_LSB +:
        mlfc_pkg::RETRY_LIMIT_W];
    assign lock = state_r.lock_s2 && (mode != mlfc_pkg::RESP_OFF);

    always_comb begin
        state_nxt = state_r;
        state_nxt.lock_s1 = current_limit_lock_i;
        state_nxt.lock_s2 = state_r.lock_s1;
        state_nxt.clr_s1 = fault_clear_i;
        state_nxt.clr_s2 = state_r.clr_s1;
        if (cfg_wr_i) begin
            state_nxt.settings = cfg_wdata_i;
        end
        case (state_r.state)
            mlfc_pkg::ST_RUN: begin
                // A clear also restarts the retry budget after auto-clears.
                if (state_r.clr_s2) begin
                    state_nxt.retries = 4'h0;
                end
                // The mode in force is captured so later writes leave it.
                if (lock) begin
                    state_nxt.resp = mode;
                    state_nxt.timer = 32'h0;
                    if (mode <= mlfc_pkg::RESP_LATCH_HIGH) begin
                        state_nxt.state = mlfc_pkg::ST_LATCHED;
                    end else if (mode != mlfc_pkg::RESP_REPORT) begin
                        state_nxt.state = mlfc_pkg::ST_RETRY;
                    end
                end
            end
            mlfc_pkg::ST_RETRY: begin
                state_nxt.timer = state_r.timer + 32'h1;
                if (state_r.timer >= 32'(RETRY_CYCLES - 1)) begin
                    state_nxt.timer = 32'h0;
                    if (state_r.retries >= {1'b0, limit}) begin
                        state_nxt.state = mlfc_pkg::ST_LATCHED;
                    end else begin
                        state_nxt.retries = state_r.retries + 4'h1;
                        state_nxt.state = mlfc_pkg::ST_RUN;
                    end
                end
            end
            default: begin
                if (state_r.clr_s2) begin
                    state_nxt.state = mlfc_pkg::ST_RUN;
                    state_nxt.retries = 4'h0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= '{settings: mlfc_pkg::SETTINGS_RESET,
                state: mlfc_pkg::ST_RUN, resp: mlfc_pkg::RESP_LATCH_HIZ,
                timer: 32'h0, retries: 4'h0, lock_s1: 1'b0, lock_s2: 1'b0,
                clr_s1: 1'b0, clr_s2: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg_rdata_o = state_r.settings;
    assign fault_latched_o = (state_r.state == mlfc_pkg::ST_LATCHED);
    // Report mode shows the lock live on the pin, with no drive change.
    assign fault_indicator_pin_n_o = !((state_r.state != mlfc_pkg::ST_RUN)
        || (state_r.lock_s2 && mode == mlfc_pkg::RESP_REPORT));
    assign drive_o = (state_r.state == mlfc_pkg::ST_RUN) ?
        mlfc_pkg::DRV_NORMAL : act_of(state_r.resp);

    always_comb begin
        detect_cfg_o.overspeed_en =
            state_r.settings[mlfc_pkg::OVERSPEED_EN_BIT];
        detect_cfg_o.backemf_en =
            state_r.settings[mlfc_pkg::BACKEMF_EN_BIT];
        detect_cfg_o.missing_en =
            state_r.settings[mlfc_pkg::MISSING_EN_BIT];
        detect_cfg_o.overspeed_pct = mlfc_pkg::OVERSPEED_BASE_PCT +
            8'(state_r.settings[mlfc_pkg::OVERSPEED_LVL_LSB +: 3]
            * mlfc_pkg::OVERSPEED_STEP_PCT);
        case (state_r.settings[mlfc_pkg::BACKEMF_LVL_LSB +: 3])
            3'h6: detect_cfg_o.backemf_pm = mlfc_pkg::BACKEMF_CODE6_PM;
            3'h7: detect_cfg_o.backemf_pm = mlfc_pkg::BACKEMF_CODE7_PM;
            default: detect_cfg_o.backemf_pm = mlfc_pkg::BACKEMF_BASE_PM +
                10'(state_r.settings[mlfc_pkg::BACKEMF_LVL_LSB +: 3]
                * mlfc_pkg::BACKEMF_STEP_PM);
        endcase
        detect_cfg_o.missing_lvl = mlfc_pkg::MISSING_LVL_TABLE[
            state_r.settings[mlfc_pkg::MISSING_LVL_LSB +: 3]];
    end

    AST_OFF_IGNORED: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RUN && mode == mlfc_pkg::RESP_OFF)
        |=> state_r.state == mlfc_pkg::ST_RUN)
        else $error("Disabled mode left run state.");
    AST_LATCH_MODES: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RUN && lock
        && mode <= mlfc_pkg::RESP_LATCH_HIGH)
        |=> fault_latched_o && !fault_indicator_pin_n_o)
        else $error("Latching mode did not latch.");
    AST_LOW_BRAKE: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RUN && lock
        && mode == mlfc_pkg::RESP_LATCH_LOW)
        |=> drive_o == mlfc_pkg::DRV_LOW_BRAKE)
        else $error("Low brake not applied.");
    AST_HIGH_BRAKE: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RUN && lock
        && mode == mlfc_pkg::RESP_LATCH_HIGH)
        |=> drive_o == mlfc_pkg::DRV_HIGH_BRAKE)
        else $error("High brake not applied.");
    AST_RETRY_ENTRY: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RUN && lock
        && mode inside {3'h3, 3'h4, 3'h5})
        |=> state_r.state == mlfc_pkg::ST_RETRY && !fault_indicator_pin_n_o)
        else $error("Retry mode did not enter retry.");
    AST_RETRY_LOW: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RETRY
        && state_r.resp == mlfc_pkg::RESP_RETRY_LOW)
        |-> drive_o == mlfc_pkg::DRV_LOW_BRAKE)
        else $error("Retry low brake missing.");
    AST_RETRY_RETURN: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RETRY
        && state_r.timer >= 32'(RETRY_CYCLES - 1)
        && state_r.retries < {1'b0, limit})
        |=> state_r.state == mlfc_pkg::ST_RUN)
        else $error("Retry did not auto-clear.");
    AST_RETRY_EXHAUST: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RETRY
        && state_r.timer >= 32'(RETRY_CYCLES - 1)
        && state_r.retries >= {1'b0, limit})
        |=> fault_latched_o)
        else $error("Retry limit did not latch.");
    AST_REPORT_ONLY: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (state_r.state == mlfc_pkg::ST_RUN && lock
        && mode == mlfc_pkg::RESP_REPORT)
        |-> !fault_indicator_pin_n_o
        ##1 drive_o == mlfc_pkg::DRV_NORMAL)
        else $error("Report mode changed outputs.");
    AST_WRITE_NEXT: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        cfg_wr_i |=> cfg_rdata_o == $past(cfg_wdata_i))
        else $error("Write not applied next cycle.");
    AST_LATCH_HOLD: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        (fault_latched_o && !state_r.clr_s2)
        |=> fault_latched_o && $stable(drive_o))
        else $error("Latched fault changed.");
endmodule // mlfc_top

// >>> logic/mlfc_pkg.sv
// Package for the motor lock fault configuration block.
package mlfc_pkg;
    localparam int REG_W = 32;
    localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
    localparam int OVERSPEED_EN_BIT = 30;
    localparam int BACKEMF_EN_BIT = 29;
    localparam int MISSING_EN_BIT = 28;
    localparam int OVERSPEED_LVL_LSB = 25;
    localparam int BACKEMF_LVL_LSB = 22;
    localparam int MISSING_LVL_LSB = 19;
    localparam int RESPONSE_LSB = 16;
    localparam int RETRY_LIMIT_W = 3;
    localparam int RETRY_LIMIT_LSB = 0;
    // Overspeed trip in percent: 130 plus 10 per code.
    localparam logic [7:0] OVERSPEED_BASE_PCT = 8'h82;
    localparam logic [7:0] OVERSPEED_STEP_PCT = 8'h0a;
    // Back-EMF trip in tenths of a percent.
    localparam logic [9:0] BACKEMF_BASE_PM = 10'h190;
    localparam logic [9:0] BACKEMF_STEP_PM = 10'h032;
    localparam logic [9:0] BACKEMF_CODE6_PM = 10'h2a3;
    localparam logic [9:0] BACKEMF_CODE7_PM = 10'h2bc;
    // Missing motor current in units of 0.1 mA.
    localparam logic [15:0] MISSING_LVL_TABLE [8] = '{16'h0177, 16'h02ee,
        16'h03e8, 16'h04e2, 16'h09c4, 16'h1388, 16'h1d4c, 16'h2710};
    // Retry interval default, in microseconds.
    localparam int RETRY_INTERVAL_US = 1000;
    localparam int CLK_MHZ = 100;
    localparam int RETRY_INTERVAL_CYC = RETRY_INTERVAL_US * CLK_MHZ;

    typedef enum logic [2:0] {
        RESP_LATCH_HIZ = 3'h0,
        RESP_LATCH_LOW = 3'h1,
        RESP_LATCH_HIGH = 3'h2,
        RESP_RETRY_HIZ = 3'h3,
        RESP_RETRY_LOW = 3'h4,
        RESP_RETRY_HIGH = 3'h5,
        RESP_REPORT = 3'h6,
        RESP_OFF = 3'h7
    } mlfc_resp_type;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_RETRY = 2'b01,
        ST_LATCHED = 2'b11
    } mlfc_state_type;

    typedef enum logic [1:0] {
        DRV_NORMAL = 2'h0,
        DRV_HIZ = 2'h1,
        DRV_LOW_BRAKE = 2'h2,
        DRV_HIGH_BRAKE = 2'h3
    } mlfc_drive_type;

    typedef struct packed {
        logic overspeed_en;
        logic backemf_en;
        logic missing_en;
        logic [7:0] overspeed_pct;
        logic [9:0] backemf_pm;
        logic [15:0] missing_lvl;
    } mlfc_detect_type;
endpackage

// >>> verification/test_mlfc_top.sv
// Self-checking bench for the motor lock fault configuration block.
`timescale 1ns/1ps
module test_mlfc_top;
    localparam int RETRY = 8;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic cfg_wr_i = 1'b0;
    logic lock = 1'b0;
    logic clr = 1'b0;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic [31:0] rdata;
    mlfc_pkg::mlfc_detect_type det;
    mlfc_pkg::mlfc_drive_type drv;
    mlfc_pkg::mlfc_drive_type drv_exp [8];
    logic ind_n;
    logic latched;
    logic [15:0] amps [8];
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    mlfc_top #(.RETRY_CYCLES(RETRY)) dut (.ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_rdata_o(rdata), .current_limit_lock_i(lock),
        .fault_clear_i(clr), .detect_cfg_o(det), .drive_o(drv),
        .fault_indicator_pin_n_o(ind_n), .fault_latched_o(latched));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // The whole run needs well under two thousand cycles.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // The strobe is dropped for one cycle so two writes never merge.
    task automatic write_reg(input logic [31:0] d);
        cfg_wr_i = 1'b1;
        cfg_wdata_i = d;
        step(1);
        cfg_wr_i = 1'b0;
        step(1);
    endtask

    task automatic clear_fault();
        lock = 1'b0;
        clr = 1'b1;
        step(3);
        clr = 1'b0;
        step(4);
        check(latched, 1'b0);
        check(drv, mlfc_pkg::DRV_NORMAL);
        check(ind_n, 1'b1);
    endtask

    initial begin
        logic [2:0] c3;
        int waited;
        amps = '{16'h0177, 16'h02ee, 16'h03e8, 16'h04e2, 16'h09c4,
            16'h1388, 16'h1d4c, 16'h2710};
        drv_exp = '{mlfc_pkg::DRV_HIZ, mlfc_pkg::DRV_LOW_BRAKE,
            mlfc_pkg::DRV_HIGH_BRAKE, mlfc_pkg::DRV_HIZ,
            mlfc_pkg::DRV_LOW_BRAKE, mlfc_pkg::DRV_HIGH_BRAKE,
            mlfc_pkg::DRV_NORMAL, mlfc_pkg::DRV_NORMAL};
        step(5);
        arst_n_i = 1'b1;
        step(1);
        check(rdata, 32'h0);
        check(det, {3'h0, 8'h82, 10'h190, 16'h0177});
        check(ind_n, 1'b1);
        check(latched, 1'b0);
        write_reg(32'hffff_ffff);
        check(rdata, 32'hffff_ffff);
        for (int c = 0; c < 8; c++) begin
            c3 = c[2:0];
            write_reg({1'b0, c3, c3, c3, c3, 3'h0, 16'h0});
            check(rdata, {1'b0, c3, c3, c3, c3, 3'h0, 16'h0});
            check(det.overspeed_en, c3[2]);
            check(det.backemf_en, c3[1]);
            check(det.missing_en, c3[0]);
            check(det.overspeed_pct, 32'h82 + 32'h0a * c);
            check(det.backemf_pm, c < 6 ? 32'h190 + 32'h32 * c :
                (c == 6 ? 32'h2a3 : 32'h2bc));
            check(det.missing_lvl, amps[c]);
        end
        // Each mode sees one short lock; a high limit keeps retries open.
        for (int m = 0; m < 8; m++) begin
            write_reg({13'h0, m[2:0], 13'h0, 3'h7});
            lock = 1'b1;
            step(4);
            check(drv, drv_exp[m]);
            check(ind_n, m == 7);
            check(latched, m < 3);
            if (m < 3) begin
                write_reg(32'h0006_0000);
                check(drv, drv_exp[m]);
            end
            lock = 1'b0;
            step(RETRY + 10);
            check(drv, m < 3 ? drv_exp[m] : mlfc_pkg::DRV_NORMAL);
            check(ind_n, m > 2);
            clear_fault();
        end
        // A lock that persists uses up the retries and then latches.
        for (int m = 3; m < 6; m += 2) begin
            write_reg({13'h0, m[2:0], 13'h0, 3'h1});
            lock = 1'b1;
            for (waited = 0; waited < 200 && latched !== 1'b1; waited++) begin
                step(1);
            end
            // Two sync flops, entry, two intervals and one re-entry cycle.
            check(waited, 2 * RETRY + 4);
            lock = 1'b0;
            step(RETRY + 6);
            check(latched, 1'b1);
            check(drv, drv_exp[m]);
            check(ind_n, 1'b0);
            clear_fault();
        end
        // A reset in mid-fault must drop the latch and the register.
        write_reg(32'h0000_0000);
        lock = 1'b1;
        step(4);
        check(latched, 1'b1);
        arst_n_i = 1'b0;
        lock = 1'b0;
        step(1);
        check(rdata, 32'h0);
        check(latched, 1'b0);
        check(drv, mlfc_pkg::DRV_NORMAL);
        arst_n_i = 1'b1;
        write_reg(32'h4000_0000);
        check(det.overspeed_en, 1'b1);
        results();
    end
endmodule // test_mlfc_top
